// File: logic/dag_core.sv
`timescale 1ns/1ps
module dag_core
  import dag_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // one access request per cycle from the core
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_byte,
  input  wire logic [1:0]  acc_op,
  input  wire logic [2:0]  acc_mode,
  input  wire logic [3:0]  acc_ptr_sel,
  input  wire logic [15:0] acc_ptr,
  input  wire logic [15:0] acc_offset,
  input  wire logic        acc_is_move,
  input  wire logic        acc_in_repeat,
  input  wire logic        acc_rpt_edge,
  input  wire logic        modulo_req,
  input  wire logic [15:0] modulo_ea,
  input  wire logic [23:0] prog_rdata,
  input  wire logic        pc_advance,
  output logic [15:0]      ea_ff,
  output logic [15:0]      ptr_wb_ff,
  output logic             ptr_wb_en_ff,
  output logic             bitrev_used_ff,
  output logic             modulo_wr_off_ff,
  output logic [23:0]      prog_addr_ff,
  output logic             prog_sel_ff,
  output logic             prog_cfg_ff,
  output logic [15:0]      tbl_rdata_ff,
  output logic [1:0]       extra_cycles_ff,
  output logic             fetch_second_ff,
  output logic [22:0]      pc_ff
);
  // =====================================================
  // registers
  logic [15:0] bitrev_control_reg_ff;
  logic [15:0] addr_mode_control_reg_ff;
  logic [7:0]  table_page_ff;
  logic [7:0]  visibility_page_ff;
  logic [15:0] core_control_reg_ff;
  logic        aw_hold_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_hold_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bitrev_enable;
  logic [3:0]  bitrev_pointer_select;
  logic [14:0] bitrev_modifier;
  logic        visibility_enable;
  assign bitrev_enable         = bitrev_control_reg_ff[BITREV_ENABLE_BIT];
  assign bitrev_modifier       = bitrev_control_reg_ff[14:0];
  assign bitrev_pointer_select = addr_mode_control_reg_ff[11:8];
  assign visibility_enable     = core_control_reg_ff[PSV_BIT];
  // =====================================================
  // axi write channel
  logic do_write;
  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff    <= 1'b0;
      aw_addr_ff    <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff    <= 1'b1;
        aw_addr_ff    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff    <= 1'b0;
      w_data_ff    <= 32'h00000000;
      w_strb_ff    <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff    <= 1'b1;
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end
  logic wr_hit;
  always_comb begin
    unique case (aw_addr_ff)
      ADDR_BREV, ADDR_MODE, ADDR_TBLPG, ADDR_PSVPG, ADDR_CORE, ADDR_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitrev_control_reg_ff    <= BREV_RST;
      addr_mode_control_reg_ff <= MODE_RST;
      table_page_ff            <= PAGE_RST;
      visibility_page_ff       <= PAGE_RST;
      core_control_reg_ff      <= CORE_RST;
    end else if (do_write) begin
      if (aw_addr_ff == ADDR_BREV)
        bitrev_control_reg_ff <= merge16(bitrev_control_reg_ff, w_data_ff, w_strb_ff);
      if (aw_addr_ff == ADDR_MODE)
        addr_mode_control_reg_ff <= merge16(addr_mode_control_reg_ff, w_data_ff, w_strb_ff);
      if (aw_addr_ff == ADDR_TBLPG && w_strb_ff[0])
        table_page_ff <= w_data_ff[7:0];
      if (aw_addr_ff == ADDR_PSVPG && w_strb_ff[0])
        visibility_page_ff <= w_data_ff[7:0];
      if (aw_addr_ff == ADDR_CORE)
        core_control_reg_ff <= merge16(core_control_reg_ff, w_data_ff, w_strb_ff);
    end
  end
  // =====================================================
  // axi read channel
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_BREV:  rd_mux = {16'h0000, bitrev_control_reg_ff};
      ADDR_MODE:  rd_mux = {16'h0000, addr_mode_control_reg_ff};
      ADDR_TBLPG: rd_mux = {24'h000000, table_page_ff};
      ADDR_PSVPG: rd_mux = {24'h000000, visibility_page_ff};
      ADDR_CORE:  rd_mux = {16'h0000, core_control_reg_ff};
      ADDR_STAT:  rd_mux = {9'h000, pc_ff};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // =====================================================
  // effective address generation
  logic        is_inc;
  logic        is_pre;
  logic        brev_active;
  logic [15:0] mod_bytes;
  logic [15:0] brev_next;
  logic [15:0] norm_ea;
  logic [15:0] norm_next;
  logic [15:0] ptr_rev;
  logic [15:0] mod_rev;
  logic [15:0] sum_rev;
  assign is_inc = (acc_mode == DAG_M_PRE_INC) || (acc_mode == DAG_M_POST_INC);
  assign is_pre = (acc_mode == DAG_M_PRE_INC) || (acc_mode == DAG_M_PRE_DEC);
  assign brev_active = acc_write && !acc_byte && is_inc && bitrev_enable &&
                       (bitrev_pointer_select != PTR_NONE) &&
                       (acc_ptr_sel == bitrev_pointer_select);
  assign mod_bytes = {bitrev_modifier, 1'b0};
  // reversed-carry add: reverse, add, reverse back
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_rev
      assign ptr_rev[gi]   = acc_ptr[15-gi];
      assign mod_rev[gi]   = mod_bytes[15-gi];
      assign brev_next[gi] = sum_rev[15-gi];
    end
  endgenerate
  assign sum_rev = ptr_rev + mod_rev;
  always_comb begin
    unique case (acc_mode)
      DAG_M_POST_INC, DAG_M_PRE_INC: norm_next = acc_ptr + acc_offset;
      DAG_M_POST_DEC, DAG_M_PRE_DEC: norm_next = acc_ptr - acc_offset;
      default:                       norm_next = acc_ptr;
    endcase
    unique case (acc_mode)
      DAG_M_PRE_INC, DAG_M_PRE_DEC: norm_ea = norm_next;
      DAG_M_REG_OFS, DAG_M_LIT_OFS: norm_ea = acc_ptr + acc_offset;
      default:                      norm_ea = acc_ptr;
    endcase
  end
  logic        use_mod;
  logic [15:0] ea_sel;
  logic [15:0] next_sel;
  always_comb begin
    use_mod  = modulo_req && !(brev_active && bitrev_enable);
    ea_sel   = norm_ea;
    next_sel = norm_next;
    if (brev_active) begin
      ea_sel   = is_pre ? {brev_next[15:1], 1'b0} : {acc_ptr[15:1], 1'b0};
      next_sel = {brev_next[15:1], 1'b0};
    end else if (use_mod) begin
      ea_sel   = modulo_ea;
      next_sel = modulo_ea;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ea_ff            <= 16'h0000;
      ptr_wb_ff        <= 16'h0000;
      ptr_wb_en_ff     <= 1'b0;
      bitrev_used_ff   <= 1'b0;
      modulo_wr_off_ff <= 1'b0;
    end else begin
      ea_ff            <= acc_valid ? ea_sel : ea_ff;
      ptr_wb_ff        <= acc_valid ? next_sel : ptr_wb_ff;
      ptr_wb_en_ff     <= acc_valid && (acc_mode inside {DAG_M_POST_INC, DAG_M_POST_DEC,
                          DAG_M_PRE_INC, DAG_M_PRE_DEC});
      bitrev_used_ff   <= acc_valid && brev_active;
      modulo_wr_off_ff <= acc_valid && brev_active && modulo_req;
    end
  end
  // =====================================================
  // program space mapping
  logic is_tbl;
  logic psv_hit;
  assign is_tbl  = acc_op != DAG_OP_DATA;
  assign psv_hit = ea_sel[15] && visibility_enable && !is_tbl;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_addr_ff <= 24'h000000;
      prog_sel_ff  <= 1'b0;
      prog_cfg_ff  <= 1'b0;
    end else begin
      prog_sel_ff <= acc_valid && (is_tbl || (psv_hit && !acc_write));
      prog_cfg_ff <= acc_valid && is_tbl && table_page_ff[CFG_BIT];
      if (acc_valid && is_tbl)
        prog_addr_ff <= {table_page_ff, ea_sel};
      else if (acc_valid && psv_hit)
        prog_addr_ff <= {1'b0, visibility_page_ff, ea_sel[14:0]};
    end
  end
  // table read data lanes, prog_rdata sampled in the same cycle prog_addr_ff is presented
  logic       rd_low_ff;
  logic       rd_high_ff;
  logic       rd_byte_ff;
  logic       rd_bsel_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_low_ff  <= 1'b0;
      rd_high_ff <= 1'b0;
      rd_byte_ff <= 1'b0;
      rd_bsel_ff <= 1'b0;
    end else begin
      rd_low_ff  <= acc_valid && !acc_write && acc_op == DAG_OP_TBL_LOW;
      rd_high_ff <= acc_valid && !acc_write && acc_op == DAG_OP_TBL_HIGH;
      rd_byte_ff <= acc_byte;
      rd_bsel_ff <= ea_sel[0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_rdata_ff <= 16'h0000;
    end else if (rd_low_ff) begin
      if (!rd_byte_ff)
        tbl_rdata_ff <= prog_rdata[15:0];
      else
        tbl_rdata_ff <= {8'h00, rd_bsel_ff ? prog_rdata[15:8] : prog_rdata[7:0]};
    end else if (rd_high_ff) begin
      if (!rd_byte_ff || !rd_bsel_ff)
        tbl_rdata_ff <= {8'h00, prog_rdata[23:16]};
      else
        tbl_rdata_ff <= 16'h0000;
    end
  end
  // =====================================================
  // visibility cycle cost and program counter
  logic [1:0] nxt_extra;
  always_comb begin
    nxt_extra = 2'h0;
    if (acc_valid && psv_hit && !acc_write) begin
      if (!acc_in_repeat)
        nxt_extra = acc_is_move ? EXTRA_ONE : EXTRA_TWO;
      else
        nxt_extra = acc_rpt_edge ? EXTRA_TWO : 2'h0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extra_cycles_ff <= 2'h0;
      fetch_second_ff <= 1'b0;
      pc_ff           <= 23'h000000;
    end else begin
      extra_cycles_ff <= nxt_extra;
      fetch_second_ff <= acc_valid && psv_hit && !acc_write;
      if (pc_advance)
        pc_ff <= pc_ff + PC_STEP;
    end
  end
  // =====================================================
  // checks
  property p_brev_lsb;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && brev_active) |=> (bitrev_used_ff && !ea_ff[0]);
  endproperty
  a_brev_lsb: assert property (p_brev_lsb) else $error("bitrev ea lsb set");
  property p_no_brev_read;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && (!acc_write || acc_byte)) |=> !bitrev_used_ff;
  endproperty
  a_no_brev_read: assert property (p_no_brev_read) else $error("bitrev on read");
  property p_brev_sel15;
    @(posedge aclk) disable iff (!aresetn)
      (bitrev_pointer_select == PTR_NONE) |=> !bitrev_used_ff;
  endproperty
  a_brev_sel15: assert property (p_brev_sel15) else $error("bitrev with select 15");
  property p_wb_offset;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && (acc_mode == DAG_M_REG_OFS || acc_mode == DAG_M_LIT_OFS)) |=> !ptr_wb_en_ff;
  endproperty
  a_wb_offset: assert property (p_wb_offset) else $error("writeback in offset mode");
  property p_tbl_addr;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && is_tbl) |=> (prog_addr_ff == {$past(table_page_ff), ea_ff});
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
  property p_psv_tbl;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && is_tbl) |-> !psv_hit;
  endproperty
  a_psv_tbl: assert property (p_psv_tbl) else $error("visibility during table op");
  property p_psv_addr;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && psv_hit) |=> (prog_addr_ff[23] == 1'b0 &&
        prog_addr_ff[15] == $past(visibility_page_ff[0]));
  endproperty
  a_psv_addr: assert property (p_psv_addr) else $error("visibility address wrong");
  property p_phantom;
    @(posedge aclk) disable iff (!aresetn)
      (rd_high_ff && rd_byte_ff && rd_bsel_ff) |=> (tbl_rdata_ff == 16'h0000);
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom byte nonzero");
  property p_pc_step;
    @(posedge aclk) disable iff (!aresetn)
      pc_advance |=> (pc_ff == $past(pc_ff) + PC_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step not two");
  property p_move_cost;
    @(posedge aclk) disable iff (!aresetn)
      (acc_valid && psv_hit && !acc_write && !acc_in_repeat && acc_is_move)
        |=> (extra_cycles_ff == EXTRA_ONE) && fetch_second_ff;
  endproperty
  a_move_cost: assert property (p_move_cost) else $error("move visibility cost");
endmodule

// File: logic/dag_pkg.sv
// Summary of operation
// - bit-reversed addresses only in x write unit, only for data writes
// - bit-reverse active when pointer select not 15, enabled, pre/post increment
// - 15-bit modifier treated bit-reversed; addresses stay in normal order
// - word data assumed; modifier scaled to bytes, address lsb forced zero
// - byte writes or other modes get the normal unreversed address
// - active mode adds pointer to modifier, ignoring the mode offset
// - bit-reverse disables circular addressing in write unit, not in read unit
// - table address is 8-bit page joined with 16-bit effective address
// - table page bit 7 selects user (0) or configuration (1) memory
// - visibility address is page joined with low 15 ea bits, user only
// - redirect to program space when ea bit 15 and visibility enable set
// - visibility drops ea bit 15, page bit 0 becomes program bit 15
// - low table read gives word, or selected byte of low word in low byte
// - high table read word mode gives bits 23:16 low, phantom byte zero
// - high table read byte mode with byte select one returns zero
// - program counter advances by two per 24-bit program word
// - visibility data read needs two fetches, extra cycles as below
// - visibility redirection suspended during table read or write
// - outside repeat, move costs one extra cycle, others two, with visibility
// - in repeat, first, last, interrupt exit and re-entry cost two extra
// - corrected address written back only for pre or post modify modes
package dag_pkg;
  // =====================================================
  // register map
  localparam logic [7:0]  ADDR_BREV   = 8'h00;
  localparam logic [7:0]  ADDR_MODE   = 8'h04;
  localparam logic [7:0]  ADDR_TBLPG  = 8'h08;
  localparam logic [7:0]  ADDR_PSVPG  = 8'h0C;
  localparam logic [7:0]  ADDR_CORE   = 8'h10;
  localparam logic [7:0]  ADDR_STAT   = 8'h14;
  // =====================================================
  // fields and reset values
  localparam int          BITREV_ENABLE_BIT    = 15;
  localparam int          PSV_BIT     = 2;
  localparam int          CFG_BIT     = 7;
  localparam logic [3:0]  PTR_NONE    = 4'hF;
  localparam logic [15:0] BREV_RST    = 16'h0000;
  localparam logic [15:0] MODE_RST    = 16'h00FF;
  localparam logic [7:0]  PAGE_RST    = 8'h00;
  localparam logic [15:0] CORE_RST    = 16'h0000;
  localparam logic [22:0] PC_STEP     = 23'h000002;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // =====================================================
  // addressing modes
  typedef enum logic [2:0] {
    DAG_M_DIRECT, DAG_M_INDIRECT, DAG_M_POST_INC, DAG_M_POST_DEC,
    DAG_M_PRE_INC, DAG_M_PRE_DEC, DAG_M_REG_OFS, DAG_M_LIT_OFS
  } dag_mode_e;
  typedef enum logic [1:0] {
    DAG_OP_DATA, DAG_OP_TBL_LOW, DAG_OP_TBL_HIGH
  } dag_op_e;
  localparam logic [1:0]  EXTRA_ONE   = 2'h1;
  localparam logic [1:0]  EXTRA_TWO   = 2'h2;
endpackage

// File: test/dag_prog_mem.sv
`timescale 1ns/1ps
module dag_prog_mem
(
  input  wire logic        aclk,
  input  wire logic [23:0] prog_addr,
  input  wire logic        prog_sel,
  output logic      [23:0] prog_rdata
);
  // =====================================================
  // program array, content derived from the address
  logic [23:0] addr_q;
  logic        live_q;
  logic [23:0] last_q = 24'h000000;

  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[7:0] ^ a[23:16] ^ 8'hC3, a[15:0] ^ 16'h5AA5};
  endfunction

  always @(posedge aclk) begin
    live_q <= prog_sel;
    addr_q <= prog_addr;
    last_q <= prog_rdata;
  end

  // held one cycle past the request, then scrambled every cycle
  always_comb begin
    if (prog_sel)
      prog_rdata = word_at(prog_addr);
    else if (live_q)
      prog_rdata = word_at(addr_q);
    else
      prog_rdata = ~last_q;
  end
endmodule

// File: test/data_address_generation_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module data_address_generation_tb_top
  import dag_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, acc_valid, acc_write, acc_byte, acc_is_move, acc_in_repeat;
  logic        acc_rpt_edge, modulo_req, pc_advance, ptr_wb_en_ff, bitrev_used_ff;
  logic        modulo_wr_off_ff, prog_sel_ff, prog_cfg_ff, fetch_second_ff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pg;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, acc_ptr_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, acc_op, extra_cycles_ff, rs;
  logic [2:0]  acc_mode;
  logic [15:0] acc_ptr, acc_offset, modulo_ea, ea_ff, ptr_wb_ff, tbl_rdata_ff, ea, ex;
  logic [23:0] prog_rdata, prog_addr_ff, w;
  logic [22:0] pc_ff;
  logic [31:0] rv [6] = '{32'(BREV_RST), 32'(MODE_RST), 32'(PAGE_RST), 32'(PAGE_RST),
                          32'(CORE_RST), 32'h0};
  logic [2:0]  xc [4] = '{3'b000, 3'b100, 3'b010, 3'b111};
  logic [1:0]  xe [4] = '{EXTRA_TWO, EXTRA_ONE, 2'h0, EXTRA_TWO};
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  dag_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_write, .acc_byte, .acc_op, .acc_mode,
    .acc_ptr_sel, .acc_ptr, .acc_offset, .acc_is_move, .acc_in_repeat, .acc_rpt_edge,
    .modulo_req, .modulo_ea, .prog_rdata, .pc_advance, .ea_ff, .ptr_wb_ff, .ptr_wb_en_ff,
    .bitrev_used_ff, .modulo_wr_off_ff, .prog_addr_ff, .prog_sel_ff, .prog_cfg_ff,
    .tbl_rdata_ff, .extra_cycles_ff, .fetch_second_ff, .pc_ff);
  dag_prog_mem i_mem (.aclk, .prog_addr(prog_addr_ff), .prog_sel(prog_sel_ff), .prog_rdata);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  // =====================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one core access, outputs settled on return except tbl_rdata_ff, which settles one cycle later
  task automatic acc(input logic wr, by, input logic [1:0] op, input logic [2:0] m,
                     input logic [15:0] p, o);
    @(posedge aclk);
    acc_write <= wr;
    acc_byte <= by;
    acc_op <= op;
    acc_mode <= m;
    acc_ptr <= p;
    acc_offset <= o;
    acc_valid <= 1'b1;
    @(posedge aclk);
    acc_valid <= 1'b0;
    #1;
  endtask

  function automatic logic [15:0] brv(input int k);
    return {11'h0, k[0], k[1], k[2], k[3], 1'b0};
  endfunction

  // =====================================================
  // tests
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, acc_valid,
     acc_write, acc_byte, acc_op, acc_mode, acc_ptr, acc_offset, acc_is_move, acc_in_repeat,
     acc_rpt_edge, modulo_req, modulo_ea, pc_advance, s_axi_awaddr, s_axi_araddr,
     s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    acc_ptr_sel = 4'h3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4));
      `CHK("reset value", rv[i], rd)
    end
    axi_wr(8'h18, 32'h1);
    `CHK("unmapped write", RESP_SLVERR, rs)
    axi_rd(8'h18);
    `CHK("unmapped read", RESP_SLVERR, rs)
    axi_wr(ADDR_BREV, 32'h8008);
    axi_rd(ADDR_BREV);
    `CHK("bitrev control", 32'h8008, rd)
    axi_wr(ADDR_MODE, 32'h03FF);
    axi_rd(ADDR_MODE);
    `CHK("mode control", 32'h03FF, rd)
    $display("test registers done");
    // buffer base aligned, no read through the pointer right away
    modulo_req <= 1'b1;
    modulo_ea <= 16'h2222;
    for (int k = 0; k < 6; k++) begin
      acc(1'b1, 1'b0, DAG_OP_DATA, DAG_M_POST_INC, 16'h1000 | brv(k), 16'h0002);
      `CHK("bitrev ea", 16'h1000 | brv(k), ea_ff)
      `CHK("bitrev next", 16'h1000 | brv(k + 1), ptr_wb_ff)
      `CHK("bitrev flags", 3'h7, {ptr_wb_en_ff, bitrev_used_ff, modulo_wr_off_ff})
    end
    acc(1'b0, 1'b0, DAG_OP_DATA, DAG_M_POST_INC, 16'h1000, 16'h0002);
    `CHK("read path", 2'b00, {bitrev_used_ff, modulo_wr_off_ff})
    `CHK("read modulo", 16'h2222, ea_ff)
    modulo_req <= 1'b0;
    acc(1'b1, 1'b0, DAG_OP_DATA, DAG_M_PRE_INC, 16'h1000, 16'h0002);
    `CHK("pre increment", 17'h11010, {bitrev_used_ff, ea_ff})
    acc(1'b1, 1'b1, DAG_OP_DATA, DAG_M_POST_INC, 16'h1000, 16'h0001);
    `CHK("byte write", 33'h010001001, {bitrev_used_ff, ea_ff, ptr_wb_ff})
    acc(1'b1, 1'b0, DAG_OP_DATA, DAG_M_REG_OFS, 16'h1000, 16'h0006);
    `CHK("offset mode", 18'h01006, {bitrev_used_ff, ptr_wb_en_ff, ea_ff})
    axi_wr(ADDR_MODE, 32'h0FFF);
    acc(1'b1, 1'b0, DAG_OP_DATA, DAG_M_POST_INC, 16'h1000, 16'h0002);
    `CHK("select 15", 33'h010001002, {bitrev_used_ff, ea_ff, ptr_wb_ff})
    $display("test bit reverse done");
    axi_wr(ADDR_CORE, 32'h4);
    for (int t = 0; t < 6; t++) begin
      pg = t[0] ? 8'h85 : 8'h12;
      ea = 16'hC2A4 | 16'(t % 3 == 2);
      w = {pg ^ ea[7:0] ^ 8'hC3, ea ^ 16'h5AA5};
      case (t)
        0: ex = w[15:0];
        1: ex = {8'h00, w[7:0]};
        2: ex = {8'h00, w[15:8]};
        5: ex = 16'h0000;
        default: ex = {8'h00, w[23:16]};
      endcase
      axi_wr(ADDR_TBLPG, {24'h0, pg});
      acc(1'b0, t % 3 != 0, t < 3 ? DAG_OP_TBL_LOW : DAG_OP_TBL_HIGH, DAG_M_INDIRECT, ea, 16'h0);
      `CHK("table addr", {pg, ea}, prog_addr_ff)
      `CHK("table space", pg[7], prog_cfg_ff)
      @(posedge aclk);
      #1;
      `CHK("table data", ex, tbl_rdata_ff)
    end
    $display("test table done");
    axi_wr(ADDR_PSVPG, 32'h35);
    for (int v = 0; v < 4; v++) begin
      {acc_is_move, acc_in_repeat, acc_rpt_edge} <= xc[v];
      acc(1'b0, 1'b0, DAG_OP_DATA, DAG_M_INDIRECT, 16'h8ABC, 16'h0);
      `CHK("window sel", 2'b10, {prog_sel_ff, prog_cfg_ff})
      `CHK("window addr", {1'b0, 8'h35, 15'h0ABC}, prog_addr_ff)
      `CHK("second fetch", 1'b1, fetch_second_ff)
      `CHK("extra cycles", xe[v], extra_cycles_ff)
    end
    acc(1'b0, 1'b0, DAG_OP_DATA, DAG_M_INDIRECT, 16'h0ABC, 16'h0);
    `CHK("low half", 1'b0, prog_sel_ff)
    axi_wr(ADDR_CORE, 32'h0);
    acc(1'b0, 1'b0, DAG_OP_DATA, DAG_M_INDIRECT, 16'h8ABC, 16'h0);
    `CHK("window off", 1'b0, prog_sel_ff)
    $display("test window done");
    @(posedge aclk);
    pc_advance <= 1'b1;
    repeat (3) @(posedge aclk);
    pc_advance <= 1'b0;
    #1;
    `CHK("pc", 23'(PC_STEP * 3), pc_ff)
    axi_wr(ADDR_STAT, 32'h40);
    axi_rd(ADDR_STAT);
    `CHK("pc read only", 32'(PC_STEP * 3), rd)
    $display("test pc done");
    complete_run();
  end
endmodule
